// [acrs_pkg.sv]
// Package: constants, timing figures and state encodings for the ADC read sequencer host.
package acrs_pkg;
   localparam int unsigned CLK_PERIOD_PS = 25000;
   // Times as printed, in their own units.
   localparam int unsigned ACQ_MIN_NS       = 1000;
   localparam int unsigned START_PULSE_NS   = 25;
   localparam int unsigned GROUP_SKEW_MAX_US = 500;
   localparam int unsigned RESET_HIGH_NS    = 50;
   localparam int unsigned RESET_TO_START_NS = 25;
   localparam int unsigned START_TO_CS_NS   = 10;
   localparam int unsigned CS_TO_BUSY_NS    = 40;
   localparam int unsigned CS_TO_START_NS   = 10;
   localparam int unsigned STROBE_PULSE_NS  = 15;
   localparam int unsigned CONV_NOM_NS      = 3000;

   function automatic int unsigned cyc_min(input int unsigned ns);
      int unsigned c;
      c = (ns * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
      return (c < 1) ? 1 : c;
   endfunction : cyc_min

   localparam int unsigned ACQ_CYC         = cyc_min(ACQ_MIN_NS);
   localparam int unsigned START_PULSE_CYC = cyc_min(START_PULSE_NS);
   localparam int unsigned GROUP_SKEW_CYC  =
      (GROUP_SKEW_MAX_US * 1000 * 1000) / CLK_PERIOD_PS;
   localparam int unsigned RESET_HIGH_CYC  = cyc_min(RESET_HIGH_NS);
   localparam int unsigned RESET_GAP_CYC   = cyc_min(RESET_TO_START_NS);
   localparam int unsigned START_CS_CYC    = cyc_min(START_TO_CS_NS);
   localparam int unsigned CS_BUSY_CYC     = cyc_min(CS_TO_BUSY_NS);
   localparam int unsigned CS_START_CYC    = cyc_min(CS_TO_START_NS);
   localparam int unsigned STROBE_CYC      = cyc_min(STROBE_PULSE_NS);
   localparam int unsigned CONV_CYC        = CONV_NOM_NS * 1000 / CLK_PERIOD_PS;

   localparam int unsigned NUM_CHANNELS = 6;
   localparam int unsigned DATA_W       = 16;
   localparam int unsigned CH_W         = 3;
   localparam int unsigned FIFO_DEPTH   = 16;
   localparam int unsigned CNT_W        = 16;
   localparam logic [CNT_W-1:0] CNT_ZERO = 16'h0000;

   typedef enum logic [8:0] {
      ST_RESET   = 9'h001,
      ST_RGAP    = 9'h002,
      ST_IDLE    = 9'h004,
      ST_START_A = 9'h008,
      ST_START_B = 9'h010,
      ST_SLOW    = 9'h020,
      ST_WAITBSY = 9'h040,
      ST_READ    = 9'h080,
      ST_GAP     = 9'h100
   } acrs_state_type;
endpackage : acrs_pkg

// [acrs_fifo.sv]
// Synchronous FIFO with valid/ready on both sides.
`timescale 1ns/1ps
`default_nettype none
module acrs_fifo #(
   parameter int unsigned WIDTH = 19,
   parameter int unsigned DEPTH = 16
) (
   input  wire logic             clk,      // System clock
   input  wire logic             rst,      // Synchronous reset, active high
   input  wire logic [WIDTH-1:0] in_data,  // Write data
   input  wire logic             in_valid, // Write request
   output logic                  in_ready, // Space available
   output logic      [WIDTH-1:0] out_data, // Head word
   output logic                  out_valid,// Head word valid
   input  wire logic             out_ready // Consumer takes word
);
   localparam int unsigned AW = $clog2(DEPTH);
   logic [WIDTH-1:0] mem_r [DEPTH];
   logic [AW-1:0]    wr_r;
   logic [AW-1:0]    rd_r;
   logic [AW:0]      cnt_r;
   logic             push;
   logic             pop;

   assign in_ready  = (cnt_r != DEPTH[AW:0]);
   assign out_valid = (cnt_r != '0);
   assign out_data  = mem_r[rd_r];
   assign push      = in_valid && in_ready;
   assign pop       = out_valid && out_ready;

   always_ff @(posedge clk) begin
      if (push) begin
         mem_r[wr_r] <= in_data;
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         wr_r  <= '0;
         rd_r  <= '0;
         cnt_r <= '0;
      end else begin
         if (push) wr_r <= wr_r + 1'b1;
         if (pop) rd_r <= rd_r + 1'b1;
         if (push && !pop) cnt_r <= cnt_r + 1'b1;
         else if (pop && !push) cnt_r <= cnt_r - 1'b1;
      end
   end
endmodule : acrs_fifo
`default_nettype wire

// [acrs_host.sv]
// Host sequencer: drives conversion starts, device reset and parallel result reads.
`timescale 1ns/1ps
`default_nettype none
module acrs_host
   import acrs_pkg::*;
#(
   parameter int unsigned GROUP_SKEW_CYCLES = GROUP_SKEW_CYC
) (
   input  wire logic              CLK_SYS,        // 40 MHz system clock
   input  wire logic              RESET,          // Synchronous reset, active high
   input  wire logic              START_REQ,      // Pulse: run one conversion cycle
   input  wire logic              SPLIT_GROUPS,   // Start groups separately
   input  wire logic              READ_DURING,    // Read while busy is high
   input  wire logic              TIED_STROBES,   // Chip select and read strobe tied
   input  wire logic [CNT_W-1:0]  GROUP_DELAY,    // Cycles from group A to B start
   input  wire logic              BUSY,           // Device busy
   input  wire logic [DATA_W-1:0] PARALLEL_RESULT_BUS, // Device result bus
   output logic                   DEV_RESET,      // Device reset, active high
   output logic                   GROUP_A_CONVERT_START, // Group A start
   output logic                   GROUP_B_CONVERT_START, // Group B start
   output logic                   CS_N,           // Chip select, active low
   output logic                   RD_N,           // Read strobe, active low
   output logic                   IDLE,           // Ready for START_REQ
   output logic [DATA_W-1:0]      RESULT_DATA,    // FIFO head data
   output logic [CH_W-1:0]        RESULT_CHAN,    // FIFO head channel
   output logic                   RESULT_VALID,   // FIFO head valid
   input  wire logic              RESULT_READY    // Consumer takes head
);
   acrs_state_type     state_r;
   logic [CNT_W-1:0]   tmr_r;
   logic [31:0]        skew_r;
   logic [CNT_W-1:0]   acq_r;
   logic [CH_W-1:0]    ch_r;
   logic [2:0]         ph_r;
   logic               busy_d_r;
   logic               split_r;
   logic               during_r;
   logic               tied_r;
   logic               dev_rst_r;
   logic               sta_r;
   logic               stb_r;
   logic               cs_n_r;
   logic               rd_n_r;
   logic               idle_r;
   logic               push_r;
   logic [DATA_W-1:0]  wdata_r;
   logic [CH_W-1:0]    wchan_r;
   logic               f_ready;
   logic               f_valid;
   logic [DATA_W+CH_W-1:0] f_out;

   function automatic logic [CNT_W-1:0] c16(input int unsigned v);
      return v[CNT_W-1:0];
   endfunction : c16

   // ---------------------------------------------------------------
   // Acquisition timer, counts cycles since busy fell
   // ---------------------------------------------------------------
   always_ff @(posedge CLK_SYS) begin
      if (RESET) begin
         busy_d_r <= 1'b0;
         acq_r    <= c16(ACQ_CYC);
      end else begin
         busy_d_r <= BUSY;
         if (BUSY) acq_r <= CNT_ZERO;
         else if (acq_r != c16(ACQ_CYC)) acq_r <= acq_r + 1'b1;
      end
   end

   // ---------------------------------------------------------------
   // Sequencer
   // ---------------------------------------------------------------
   always_ff @(posedge CLK_SYS) begin
      if (RESET) begin
         state_r   <= ST_RESET;
         tmr_r     <= CNT_ZERO;
         skew_r    <= 32'h00000000;
         ch_r      <= '0;
         ph_r      <= 3'h0;
         split_r   <= 1'b0;
         during_r  <= 1'b0;
         tied_r    <= 1'b0;
         dev_rst_r <= 1'b1;
         sta_r     <= 1'b0;
         stb_r     <= 1'b0;
         cs_n_r    <= 1'b1;
         rd_n_r    <= 1'b1;
         idle_r    <= 1'b0;
         push_r    <= 1'b0;
         wdata_r   <= '0;
         wchan_r   <= '0;
      end else begin
         push_r <= 1'b0;
         if (tmr_r != CNT_ZERO) tmr_r <= tmr_r - 1'b1;
         if (skew_r != 32'h00000000) skew_r <= skew_r - 1;
         case (state_r)
            ST_RESET: begin
               if (tmr_r == CNT_ZERO && dev_rst_r) begin
                  tmr_r <= c16(RESET_HIGH_CYC - 1);
                  dev_rst_r <= 1'b1;
                  state_r <= ST_RGAP;
               end
            end
            ST_RGAP: begin
               if (dev_rst_r) begin
                  if (tmr_r == CNT_ZERO) begin
                     dev_rst_r <= 1'b0;
                     tmr_r <= c16(RESET_GAP_CYC);
                  end
               end else if (tmr_r == CNT_ZERO) begin
                  state_r <= ST_IDLE;
                  idle_r <= 1'b1;
               end
            end
            ST_IDLE: begin
               // Low time of the previous start pulse and the read gap both
               // expire before a new start; acquisition must also have run.
               if (START_REQ && tmr_r == CNT_ZERO && acq_r == c16(ACQ_CYC)
                   && !BUSY) begin
                  idle_r   <= 1'b0;
                  split_r  <= SPLIT_GROUPS;
                  during_r <= READ_DURING;
                  tied_r   <= TIED_STROBES;
                  sta_r    <= 1'b1;
                  stb_r    <= !SPLIT_GROUPS;
                  tmr_r    <= c16(START_PULSE_CYC - 1);
                  state_r  <= ST_START_A;
               end
            end
            ST_START_A: begin
               if (tmr_r == CNT_ZERO) begin
                  sta_r <= 1'b0;
                  stb_r <= 1'b0;
                  if (split_r) begin
                     // Clamp the requested skew to the allowed window.
                     skew_r <= (GROUP_DELAY > GROUP_SKEW_CYCLES) ?
                               GROUP_SKEW_CYCLES : 32'(GROUP_DELAY);
                     state_r <= ST_START_B;
                  end else begin
                     tmr_r <= c16(START_PULSE_CYC);
                     state_r <= ST_WAITBSY;
                  end
               end
            end
            ST_START_B: begin
               if (skew_r <= 32'(START_PULSE_CYC + 1) && !stb_r) begin
                  stb_r <= 1'b1;
                  tmr_r <= c16(START_PULSE_CYC - 1);
                  state_r <= ST_SLOW;
               end
            end
            ST_SLOW: begin
               if (tmr_r == CNT_ZERO) begin
                  stb_r <= 1'b0;
                  tmr_r <= c16(START_PULSE_CYC);
                  state_r <= ST_WAITBSY;
               end
            end
            ST_WAITBSY: begin
               // Device raises busy on the start edge; wait for the right window.
               if (during_r && BUSY) begin
                  if (tmr_r <= c16(START_PULSE_CYC - START_CS_CYC)) begin
                     cs_n_r <= 1'b0;
                     ch_r <= '0;
                     ph_r <= 3'h0;
                     state_r <= ST_READ;
                  end
               end else if (!during_r && !BUSY && busy_d_r) begin
                  cs_n_r <= 1'b0;
                  ch_r <= '0;
                  ph_r <= 3'h0;
                  state_r <= ST_READ;
               end
            end
            ST_READ: begin
               // Phases: 0 strobe low, 1 hold low, 2 capture, 3 high time.
               // Six words take well under busy minus the guard, so the read
               // during conversion ends early enough when the FIFO keeps up.
               ph_r <= ph_r + 3'h1;
               case (ph_r)
                  3'h0: rd_n_r <= tied_r ? 1'b1 : 1'b0;
                  3'h1: begin
                     if (tied_r) cs_n_r <= 1'b0;
                  end
                  3'h2: begin
                     if (f_ready) begin
                        wdata_r <= PARALLEL_RESULT_BUS;
                        wchan_r <= ch_r;
                        push_r  <= 1'b1;
                        rd_n_r  <= 1'b1;
                        if (tied_r) cs_n_r <= 1'b1;
                     end else begin
                        ph_r <= 3'h2;
                     end
                  end
                  3'h3: begin
                     ph_r <= 3'h0;
                     if (ch_r == CH_W'(NUM_CHANNELS - 1)) begin
                        cs_n_r <= 1'b1;
                        tmr_r <= c16(CS_START_CYC);
                        state_r <= ST_GAP;
                     end else begin
                        ch_r <= ch_r + 1'b1;
                        if (tied_r) cs_n_r <= 1'b0;
                        ph_r <= 3'h1;
                        rd_n_r <= tied_r ? 1'b1 : 1'b0;
                     end
                  end
                  default: ph_r <= 3'h0;
               endcase
            end
            ST_GAP: begin
               if (tmr_r == CNT_ZERO) begin
                  tmr_r <= c16(CS_START_CYC);
                  idle_r <= 1'b1;
                  state_r <= ST_IDLE;
               end
            end
            default: state_r <= ST_IDLE;
         endcase
      end
   end

   // ---------------------------------------------------------------
   // Output registers and result buffer
   // ---------------------------------------------------------------
   always_ff @(posedge CLK_SYS) begin
      if (RESET) begin
         DEV_RESET <= 1'b1;
         GROUP_A_CONVERT_START <= 1'b0;
         GROUP_B_CONVERT_START <= 1'b0;
         CS_N <= 1'b1;
         RD_N <= 1'b1;
         IDLE <= 1'b0;
      end else begin
         DEV_RESET <= dev_rst_r;
         GROUP_A_CONVERT_START <= sta_r;
         GROUP_B_CONVERT_START <= stb_r;
         CS_N <= cs_n_r;
         RD_N <= tied_r ? cs_n_r : rd_n_r;
         IDLE <= idle_r;
      end
   end

   acrs_fifo #(
      .WIDTH(DATA_W + CH_W),
      .DEPTH(FIFO_DEPTH)
   ) u_fifo (
      .clk      (CLK_SYS),
      .rst      (RESET),
      .in_data  ({wchan_r, wdata_r}),
      .in_valid (push_r),
      .in_ready (f_ready),
      .out_data (f_out),
      .out_valid(f_valid),
      .out_ready(RESULT_READY)
   );

   always_ff @(posedge CLK_SYS) begin
      if (RESET) begin
         RESULT_DATA  <= '0;
         RESULT_CHAN  <= '0;
         RESULT_VALID <= 1'b0;
      end else begin
         RESULT_DATA  <= f_out[DATA_W-1:0];
         RESULT_CHAN  <= f_out[DATA_W+CH_W-1:DATA_W];
         RESULT_VALID <= f_valid && !RESULT_READY;
      end
   end
endmodule : acrs_host
`default_nettype wire

// [acrs_host_props.sv]
// Concurrent checks on the device-side pins of the host sequencer.
`timescale 1ns/1ps
`default_nettype none
module acrs_host_props
   import acrs_pkg::*;
#(
   parameter int unsigned GROUP_SKEW_CYCLES = GROUP_SKEW_CYC
) (
   input wire logic CLK_SYS,               // System clock
   input wire logic RESET,                 // Synchronous reset
   input wire logic READ_DURING,           // Read while busy
   input wire logic BUSY,                  // Device busy
   input wire logic DEV_RESET,             // Device reset
   input wire logic GROUP_A_CONVERT_START, // Group A start
   input wire logic GROUP_B_CONVERT_START, // Group B start
   input wire logic CS_N,                  // Chip select
   input wire logic RD_N                   // Read strobe
);
   default clocking cb @(posedge CLK_SYS); endclocking
   default disable iff (RESET);

   // Saturates so that the first start after reset never counts as short.
   logic [7:0] acq_r;
   always_ff @(posedge CLK_SYS) begin
      if (RESET) acq_r <= 8'hFF;
      else if ($fell(BUSY)) acq_r <= 8'h01;
      else if (acq_r != 8'hFF) acq_r <= acq_r + 8'h01;
   end

   // Cycles since group A rose while group B is still low. A counter is used
   // because the real skew limit is far too long for a delay range.
   logic [31:0] skew_r;
   always_ff @(posedge CLK_SYS) begin
      if (RESET) skew_r <= 32'h00000000;
      else if (GROUP_B_CONVERT_START) skew_r <= 32'h00000000;
      else if ($rose(GROUP_A_CONVERT_START) || skew_r != 32'h00000000) begin
         skew_r <= skew_r + 32'h00000001;
      end
   end

   // ------------------------------------------------------------
   // Checks
   // ------------------------------------------------------------
   sequence s_start_rise;
      $rose(GROUP_A_CONVERT_START) || $rose(GROUP_B_CONVERT_START);
   endsequence
   sequence s_cs_read_open;
      $fell(CS_N) && !READ_DURING;
   endsequence

   a_acq_time_min: assert property (s_start_rise |-> acq_r >= ACQ_CYC)
      else $error("start raised before acquisition time");
   a_pulse_a_len: assert property ($rose(GROUP_A_CONVERT_START) |=> !GROUP_A_CONVERT_START)
      else $error("group A start pulse width wrong");
   a_pulse_b_len: assert property ($rose(GROUP_B_CONVERT_START) |=> !GROUP_B_CONVERT_START)
      else $error("group B start pulse width wrong");
   a_group_skew_max: assert property (skew_r <= GROUP_SKEW_CYCLES)
      else $error("group B start too late");
   a_dev_reset_len: assert property ($fell(DEV_RESET) |-> $past(DEV_RESET, 2))
      else $error("device reset pulse too short");
   a_reset_start_gap: assert property (s_start_rise |-> !$past(DEV_RESET))
      else $error("start too soon after device reset");
   a_cs_after_start: assert property (s_start_rise |-> CS_N)
      else $error("chip select low at start edge");
   a_cs_before_busy: assert property ($fell(BUSY) |-> $past(CS_N) && $past(CS_N, 2))
      else $error("read still open near busy fall");
   a_cs_after_busy: assert property (s_cs_read_open |-> !BUSY)
      else $error("read began before busy fell");
   a_cs_before_start: assert property (s_start_rise |-> $past(CS_N))
      else $error("chip select released too late");
   a_strobe_in_frame: assert property (!RD_N |-> !CS_N)
      else $error("read strobe outside chip select");
endmodule : acrs_host_props

bind acrs_host acrs_host_props #(
   .GROUP_SKEW_CYCLES(GROUP_SKEW_CYCLES)
) acrs_host_props_i (
   .CLK_SYS(CLK_SYS), .RESET(RESET), .READ_DURING(READ_DURING), .BUSY(BUSY),
   .DEV_RESET(DEV_RESET), .GROUP_A_CONVERT_START(GROUP_A_CONVERT_START),
   .GROUP_B_CONVERT_START(GROUP_B_CONVERT_START), .CS_N(CS_N), .RD_N(RD_N)
);
`default_nettype wire

// [acrs_adc_model.sv]
// Behavioural model of the six-channel converter that the host drives.
`timescale 1ns/1ps
`default_nettype none
module acrs_adc_model
   import acrs_pkg::*;
#(
   parameter int unsigned CONV_CYCLES = CONV_CYC,
   parameter logic [12:0] WORD_TAG    = 13'h1A5C
) (
   input  wire logic         clk,     // System clock
   input  wire logic         dev_rst, // Device reset, active high
   input  wire logic         start_a, // Group A start
   input  wire logic         start_b, // Group B start
   input  wire logic         cs_n,    // Chip select, active low
   input  wire logic         rd_n,    // Read strobe, active low
   output logic              busy,    // Conversion in progress
   output logic [DATA_W-1:0] data     // Parallel result bus
);
   logic              a_q, b_q, rd_q;
   logic [7:0]        conv_r;
   logic [CH_W-1:0]   ch_r;
   logic [DATA_W-1:0] word_r;

   always @(posedge clk) begin
      a_q <= start_a;
      b_q <= start_b;
      rd_q <= rd_n;
      if (dev_rst) begin
         busy <= 1'b0;
         ch_r <= 3'h0;
         word_r <= 16'h0000;
      end else if (busy) begin
         conv_r <= conv_r + 8'h01;
         if (conv_r == 8'(CONV_CYCLES - 1)) busy <= 1'b0;
      end else if ((start_a && !a_q) || (start_b && !b_q)) begin
         busy <= 1'b1;
         conv_r <= 8'h00;
         ch_r <= 3'h0;
      end
      // The channel advances when the strobe rises, so the word for the
      // current channel already stands while the strobe is still low.
      if (!dev_rst && rd_n && !rd_q) begin
         word_r <= {WORD_TAG, ch_r};
         ch_r <= ch_r + 3'h1;
      end
   end

   // A released bus shows the inverse of the last word, never a held value.
   assign data = (!cs_n && !rd_n) ? {WORD_TAG, ch_r} : ~word_r;
endmodule : acrs_adc_model
`default_nettype wire

// [acrs_host_bench.sv]
// Self-checking bench for the host sequencer against the converter model.
`timescale 1ns/1ps
`default_nettype none
`define CHK(got, exp) begin \
   n_tests++; \
   if ((got) !== (exp)) begin \
      bad_count++; \
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp); \
   end \
end
module acrs_host_bench
   import acrs_pkg::*;
;
   localparam int unsigned SKEW = 200;
   localparam logic [12:0] TAG  = 13'h1A5C;
   logic              clk_sys, reset, start_req, split_groups, read_during;
   logic              tied_strobes, busy, dev_reset, ga, gb, cs_n, rd_n, idle;
   logic              result_valid, result_ready;
   logic [CNT_W-1:0]  group_delay;
   logic [DATA_W-1:0] bus, result_data;
   logic [CH_W-1:0]   result_chan;
   int                bad_count = 0;
   int                n_tests = 0;

   acrs_host #(.GROUP_SKEW_CYCLES(SKEW)) acrs_host_i (
      .CLK_SYS(clk_sys), .RESET(reset), .START_REQ(start_req),
      .SPLIT_GROUPS(split_groups), .READ_DURING(read_during),
      .TIED_STROBES(tied_strobes), .GROUP_DELAY(group_delay), .BUSY(busy),
      .PARALLEL_RESULT_BUS(bus), .DEV_RESET(dev_reset), .GROUP_A_CONVERT_START(ga),
      .GROUP_B_CONVERT_START(gb), .CS_N(cs_n), .RD_N(rd_n), .IDLE(idle),
      .RESULT_DATA(result_data), .RESULT_CHAN(result_chan),
      .RESULT_VALID(result_valid), .RESULT_READY(result_ready));
   acrs_adc_model #(.WORD_TAG(TAG)) acrs_adc_model_i (
      .clk(clk_sys), .dev_rst(dev_reset), .start_a(ga), .start_b(gb),
      .cs_n(cs_n), .rd_n(rd_n), .busy(busy), .data(bus));

   initial begin
      clk_sys = 1'b0;
      forever #12.5 clk_sys = ~clk_sys;
   end

   always @(posedge clk_sys)
      if (tied_strobes === 1'b1 && cs_n === 1'b0) `CHK(rd_n, cs_n)

   task automatic summarize;
      $display("Mismatches %0d in %0d checks", bad_count, n_tests);
      if (bad_count == 0 && n_tests > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask : summarize

   task automatic tick(input int n);
      repeat (n) @(posedge clk_sys);
      #1;
   endtask : tick

   task automatic wait_idle;
      int k;
      k = 0;
      while (idle !== 1'b1 && k < 3000) begin tick(1); k++; end
      if (k == 3000) begin bad_count++; summarize(); end
   endtask : wait_idle

   // Request is held until taken, since acquisition may delay acceptance.
   task automatic convert(input logic sp, du, ti, input logic [CNT_W-1:0] dl);
      int k;
      wait_idle();
      split_groups = sp; read_during = du; tied_strobes = ti; group_delay = dl;
      start_req = 1'b1;
      k = 0;
      while (idle === 1'b1 && k < 200) begin tick(1); k++; end
      start_req = 1'b0;
      if (k == 200) begin bad_count++; summarize(); end
   endtask : convert

   task automatic drain(input int n);
      int k;
      for (int i = 0; i < n; i++) begin
         k = 0;
         while (result_valid !== 1'b1 && k < 3000) begin tick(1); k++; end
         if (k == 3000) begin bad_count++; summarize(); end
         `CHK(result_chan, CH_W'(i % NUM_CHANNELS))
         `CHK(result_data, {TAG, CH_W'(i % NUM_CHANNELS)})
         result_ready = 1'b1;
         tick(1);
         result_ready = 1'b0;
         tick(1);
      end
   endtask : drain

   // ------------------------------------------------------------
   // Scenarios
   // ------------------------------------------------------------
   task automatic t_modes;
      for (int m = 0; m < 4; m++) begin
         convert(1'b0, m[0], m[1], 16'h0000);
         wait_idle();
         drain(6);
      end
   endtask : t_modes

   task automatic t_split(input logic [CNT_W-1:0] dl, input int exp);
      int k;
      convert(1'b1, 1'b0, 1'b0, dl);
      k = 0;
      while (gb !== 1'b1 && k < 1000) begin tick(1); k++; end
      if (k == 1000) begin bad_count++; summarize(); end
      `CHK(k, exp)
      wait_idle();
      drain(6);
   endtask : t_split

   // Three frames into a 16-word buffer: capture must stall, then resume.
   task automatic t_fill;
      for (int c = 0; c < 3; c++) convert(1'b0, 1'b0, 1'b0, 16'h0000);
      tick(300);
      `CHK(idle, 1'b0)
      `CHK(cs_n, 1'b0)
      drain(18);
      wait_idle();
   endtask : t_fill

   task automatic t_reset;
      reset = 1'b1;
      tick(2);
      `CHK(dev_reset, 1'b1)
      `CHK(cs_n, 1'b1)
      reset = 1'b0;
      convert(1'b0, 1'b1, 1'b0, 16'h0000);
      wait_idle();
      drain(6);
   endtask : t_reset

   initial begin
      reset = 1'b1; start_req = 1'b0; split_groups = 1'b0; read_during = 1'b0;
      tied_strobes = 1'b0; group_delay = 16'h0000; result_ready = 1'b0;
      tick(2);
      reset = 1'b0;
      t_modes();
      t_split(16'h0032, 50);
      t_split(16'h0FFF, SKEW);
      t_fill();
      t_reset();
      summarize();
   end
endmodule : acrs_host_bench
`default_nettype wire
